// >>> hw/crs_core_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "crs_map.svh"
module crs_core_regs
(
	input wire logic clk,
	input wire logic reset,
	// Resolved request levels, active high
	input wire logic nmi_req,
	input wire logic int_req,
	input wire logic bus_request,
	// Sequencing strobes from the instruction decoder
	input wire logic instr_last,
	input wire logic fetch_cycle,
	input wire logic pc_step,
	input wire logic push_op,
	input wire logic pop_op,
	input wire logic swap_af,
	input wire logic swap_gen,
	input wire logic op_ei,
	input wire logic op_di,
	input wire logic op_retn,
	input wire logic op_mode,
	input wire logic [1:0] mode_val,
	// Register write and read port
	input wire logic wr_en,
	input wire logic [4:0] wr_sel,
	input wire logic [15:0] wr_data,
	input wire logic [4:0] rd_sel,
	output logic [15:0] rd_data,
	// Acknowledge vector byte from the peripheral
	input wire logic ack_valid,
	input wire logic [7:0] ack_vector,
	// Interrupt entry outputs
	output logic int_ack,
	output logic insert_opcode,
	output logic nmi_taken,
	output logic int_taken,
	output logic [15:0] service_addr,
	// Core state outputs
	output logic [15:0] pc_out,
	output logic [15:0] sp_out,
	output logic [7:0] refresh_addr,
	output logic refresh_drive,
	output logic enable_flop_first,
	output logic enable_flop_second,
	output logic [1:0] response_mode_flops
);
	// =========================================================
	// Storage
	// =========================================================
	// 2x(A,F)+2x6 general+I+R = 144 bits, IX,IY,SP,PC 64: 208 with flags
	logic [7:0] af_q [0:1][0:1]; // Bank, then accumulator/flags
	logic [7:0] gen_q [0:1][0:5]; // Bank, then B C D E H L
	logic af_bank_q; // Active accumulator/flag bank
	logic gen_bank_q; // Active general bank
	logic [7:0] vbase_q; // Vector base
	logic [7:0] refresh_q; // Refresh counter
	logic [15:0] idx1_q; // First index
	logic [15:0] idx2_q; // Second index
	logic [15:0] sp_q; // Stack pointer
	logic [15:0] pc_q; // Program counter
	logic en1_q; // First enable flop
	logic en2_q; // Second enable flop
	crs_pkg::crs_mode_t mode_q; // Response mode flops
	crs_pkg::crs_state_t state_q; // Entry sequencer
	logic [15:0] target_q; // Address to load at entry
	logic nmi_kind_q; // Entry in progress is non-maskable
	logic [15:0] rd_data_q; // Read data
	logic int_ack_q; // Acknowledge asserted
	logic insert_q; // Next opcode comes off the data bus
	logic nmi_taken_q; // One-cycle entry pulse
	logic int_taken_q; // One-cycle entry pulse
	logic [7:0] refresh_addr_q; // Refresh value on address bus
	logic refresh_drive_q; // Refresh address valid
	// =========================================================
	// Decode helpers
	// =========================================================
	// Write strobe for one select code
	function automatic logic hit(input logic [4:0] sel);
		hit = wr_en && (wr_sel == sel);
	endfunction
	// Pair with first register as high byte
	function automatic logic [15:0] pair(input logic [7:0] hi, input logic [7:0] lo);
		pair = {hi, lo};
	endfunction
	// Sampling decisions at the instruction boundary
	logic take_nmi; // Non-maskable accepted this edge
	logic take_int; // Maskable accepted this edge
	// Decide only on the last clock of an instruction
	// Held off while the bus is requested
	assign take_nmi = instr_last && nmi_req && !bus_request && state_q == crs_pkg::CRS_IDLE;
	// Maskable gated by the first enable flop
	// Loses to a simultaneous non-maskable, stays pending
	assign take_int = instr_last && int_req && en1_q && !nmi_req && !bus_request
		&& state_q == crs_pkg::CRS_IDLE;
	// Lines arrive already wired-OR; only high means asserted
	// =========================================================
	// Accumulator, flag and general banks
	// =========================================================
	// Swaps flip the bank pointer, contents stay put
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			af_bank_q <= 1'b0;
			gen_bank_q <= 1'b0;
		end
		else
		begin
			// Toggle active bank
			if (swap_af)
				af_bank_q <= ~af_bank_q;
			if (swap_gen)
				gen_bank_q <= ~gen_bank_q;
		end
	end
	// Accumulator and flags written with operands and results
	// Decoder presents every instruction as these writes
	always_ff @(posedge clk)
	begin
		// Byte writes to the active bank
		if (hit(`CRS_SEL_ACC))
			af_q[af_bank_q][0] <= wr_data[7:0];
		if (hit(`CRS_SEL_FLAG))
			af_q[af_bank_q][1] <= wr_data[7:0];
	end
	// Single bytes or 16-bit pairs, high byte first
	always_ff @(posedge clk)
	begin
		// Single register writes
		for (int i = 0; i < 6; i++)
		begin
			if (hit(5'(`CRS_SEL_B_HI + i)))
				gen_q[gen_bank_q][i] <= wr_data[7:0];
		end
		// Pair writes, high byte to the even register
		for (int p = 0; p < 3; p++)
		begin
			if (hit(5'(`CRS_SEL_PAIR1 + p)))
			begin
				gen_q[gen_bank_q][2 * p] <= wr_data[15:8];
				gen_q[gen_bank_q][2 * p + 1] <= wr_data[7:0];
			end
		end
	end
	// =========================================================
	// Special-purpose registers
	// =========================================================
	// Vector base and index bases, plain storage
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			vbase_q <= `CRS_RST_BYTE;
			idx1_q <= `CRS_RST_WORD;
			idx2_q <= `CRS_RST_WORD;
		end
		else
		begin
			if (hit(`CRS_SEL_VBASE))
				vbase_q <= wr_data[7:0];
			if (hit(`CRS_SEL_IDX1))
				idx1_q <= wr_data;
			if (hit(`CRS_SEL_IDX2))
				idx2_q <= wr_data;
		end
	end
	// Refresh counter steps on each fetch, write wins
	always_ff @(posedge clk)
	begin
		if (reset)
			refresh_q <= `CRS_RST_BYTE;
		else if (hit(`CRS_SEL_REFRESH))
			refresh_q <= wr_data[7:0];
		else if (fetch_cycle)
			refresh_q <= refresh_q + 8'h01;
	end
	// Present the pre-step count in the cycle after the fetch
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			refresh_addr_q <= `CRS_RST_BYTE;
			refresh_drive_q <= 1'b0;
		end
		else
		begin
			refresh_drive_q <= fetch_cycle;
			if (fetch_cycle)
				refresh_addr_q <= refresh_q;
		end
	end
	// Push moves down two bytes, pop up two
	always_ff @(posedge clk)
	begin
		if (reset)
			sp_q <= `CRS_RST_WORD;
		else if (hit(`CRS_SEL_SP))
			sp_q <= wr_data;
		else if (push_op)
			sp_q <= sp_q - `CRS_SP_STEP;
		else if (pop_op)
			sp_q <= sp_q + `CRS_SP_STEP;
	end
	// Next fetch address; entry load has top priority
	always_ff @(posedge clk)
	begin
		if (reset)
			pc_q <= `CRS_RST_WORD;
		else if (state_q == crs_pkg::CRS_ENTER)
			pc_q <= target_q;
		else if (hit(`CRS_SEL_PC))
			pc_q <= wr_data;
		else if (pc_step)
			pc_q <= pc_q + 16'h0001;
	end
	// =========================================================
	// Interrupt status flops
	// =========================================================
	// Reset/disable clear both, enable sets both
	// Two enable flops kept apart from the mode pair
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			en1_q <= 1'b0;
			en2_q <= 1'b0;
		end
		else if (take_nmi)
		begin
			// Save first into second, then mask
			en2_q <= en1_q;
			en1_q <= 1'b0;
		end
		else if (take_int || op_di)
		begin
			// Maskable entry also masks further requests
			en1_q <= 1'b0;
			en2_q <= 1'b0;
		end
		else if (op_ei)
		begin
			en1_q <= 1'b1;
			en2_q <= 1'b1;
		end
		else if (op_retn)
			en1_q <= en2_q;
	end
	// Mode selected by software; unknown code is ignored
	always_ff @(posedge clk)
	begin
		if (reset)
			mode_q <= crs_pkg::CRS_MODE_INSERT;
		else if (op_mode && mode_val != 2'b11)
			mode_q <= crs_pkg::crs_mode_t'(mode_val);
	end
	// =========================================================
	// Interrupt entry sequencer
	// =========================================================
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_q <= crs_pkg::CRS_IDLE;
			target_q <= `CRS_RST_WORD;
			nmi_kind_q <= 1'b0;
			int_ack_q <= 1'b0;
			insert_q <= 1'b0;
		end
		else
		begin
			unique case (state_q)
				crs_pkg::CRS_IDLE:
				begin
					// Mode 0 insertion lasts one fetch
					if (fetch_cycle)
						insert_q <= 1'b0;
					if (take_nmi)
					begin
						target_q <= `CRS_NMI_ADDR;
						nmi_kind_q <= 1'b1;
						state_q <= crs_pkg::CRS_ENTER;
					end
					else if (take_int)
					begin
						nmi_kind_q <= 1'b0;
						unique case (mode_q)
							crs_pkg::CRS_MODE_FIXED:
							begin
								target_q <= `CRS_MODE1_ADDR;
								state_q <= crs_pkg::CRS_ENTER;
							end
							crs_pkg::CRS_MODE_VECTOR:
							begin
								int_ack_q <= 1'b1;
								state_q <= crs_pkg::CRS_ACK;
							end
							default:
							begin
								// Insertion: opcode taken off the data bus
								int_ack_q <= 1'b1;
								insert_q <= 1'b1;
							end
						endcase
					end
					else if (insert_q && fetch_cycle)
						int_ack_q <= 1'b0;
				end
				crs_pkg::CRS_ACK:
				begin
					// Wait for the peripheral's vector byte
					if (ack_valid)
					begin
						// Vector base is the high byte, bit 0 forced low
						target_q <= {vbase_q, ack_vector[7:1], 1'b0};
						int_ack_q <= 1'b0;
						state_q <= crs_pkg::CRS_ENTER;
					end
				end
				crs_pkg::CRS_ENTER:
				begin
					// Program counter loads this cycle
					state_q <= crs_pkg::CRS_IDLE;
				end
				default:
					state_q <= crs_pkg::CRS_IDLE;
			endcase
		end
	end
	// Entry pulses, one cycle as the program counter loads, or after mode 0 acceptance with no load
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			nmi_taken_q <= 1'b0;
			int_taken_q <= 1'b0;
		end
		else
		begin
			nmi_taken_q <= (state_q == crs_pkg::CRS_ENTER) && nmi_kind_q;
			int_taken_q <= ((state_q == crs_pkg::CRS_ENTER) && !nmi_kind_q)
				|| (take_int && mode_q == crs_pkg::CRS_MODE_INSERT);
		end
	end
	// =========================================================
	// Read port
	// =========================================================
	logic [15:0] rd_mux; // Selected register value
	always_comb
	begin
		rd_mux = `CRS_RST_WORD;
		unique case (rd_sel)
			`CRS_SEL_ACC: rd_mux = {8'h00, af_q[af_bank_q][0]};
			`CRS_SEL_FLAG: rd_mux = {8'h00, af_q[af_bank_q][1]};
			`CRS_SEL_B_HI: rd_mux = {8'h00, gen_q[gen_bank_q][0]};
			`CRS_SEL_B_LO: rd_mux = {8'h00, gen_q[gen_bank_q][1]};
			`CRS_SEL_D_HI: rd_mux = {8'h00, gen_q[gen_bank_q][2]};
			`CRS_SEL_D_LO: rd_mux = {8'h00, gen_q[gen_bank_q][3]};
			`CRS_SEL_H_HI: rd_mux = {8'h00, gen_q[gen_bank_q][4]};
			`CRS_SEL_H_LO: rd_mux = {8'h00, gen_q[gen_bank_q][5]};
			`CRS_SEL_VBASE: rd_mux = {8'h00, vbase_q};
			`CRS_SEL_REFRESH: rd_mux = {8'h00, refresh_q};
			`CRS_SEL_IDX1: rd_mux = idx1_q;
			`CRS_SEL_IDX2: rd_mux = idx2_q;
			`CRS_SEL_SP: rd_mux = sp_q;
			`CRS_SEL_PC: rd_mux = pc_q;
			`CRS_SEL_PAIR1: rd_mux = pair(gen_q[gen_bank_q][0], gen_q[gen_bank_q][1]);
			`CRS_SEL_PAIR2: rd_mux = pair(gen_q[gen_bank_q][2], gen_q[gen_bank_q][3]);
			`CRS_SEL_PAIR3: rd_mux = pair(gen_q[gen_bank_q][4], gen_q[gen_bank_q][5]);
			`CRS_SEL_STATUS:
			begin
				rd_mux[`CRS_ST_EN1] = en1_q;
				rd_mux[`CRS_ST_EN2] = en2_q;
				rd_mux[`CRS_ST_MODE_HI:`CRS_ST_MODE_LO] = mode_q;
				rd_mux[`CRS_ST_BANK_AF] = af_bank_q;
				rd_mux[`CRS_ST_BANK_GEN] = gen_bank_q;
			end
			default: rd_mux = `CRS_RST_WORD;
		endcase
	end
	// Registered read, one cycle after the select
	always_ff @(posedge clk)
	begin
		if (reset)
			rd_data_q <= `CRS_RST_WORD;
		else
			rd_data_q <= rd_mux;
	end
	// =========================================================
	// Outputs
	// =========================================================
	assign rd_data = rd_data_q;
	assign int_ack = int_ack_q;
	assign insert_opcode = insert_q;
	assign nmi_taken = nmi_taken_q;
	assign int_taken = int_taken_q;
	assign service_addr = pc_q;
	assign pc_out = pc_q;
	assign sp_out = sp_q;
	assign refresh_addr = refresh_addr_q;
	assign refresh_drive = refresh_drive_q;
	assign enable_flop_first = en1_q;
	assign enable_flop_second = en2_q;
	assign response_mode_flops = mode_q;
endmodule
`default_nettype wire

// >>> hw/crs_map.svh
`ifndef CRS_MAP_SVH
`define CRS_MAP_SVH
// Register select codes on the access port
`define CRS_SEL_ACC 5'h00
`define CRS_SEL_FLAG 5'h01
`define CRS_SEL_B_HI 5'h02
`define CRS_SEL_B_LO 5'h03
`define CRS_SEL_D_HI 5'h04
`define CRS_SEL_D_LO 5'h05
`define CRS_SEL_H_HI 5'h06
`define CRS_SEL_H_LO 5'h07
`define CRS_SEL_VBASE 5'h08
`define CRS_SEL_REFRESH 5'h09
`define CRS_SEL_IDX1 5'h0a
`define CRS_SEL_IDX2 5'h0b
`define CRS_SEL_SP 5'h0c
`define CRS_SEL_PC 5'h0d
`define CRS_SEL_PAIR1 5'h0e
`define CRS_SEL_PAIR2 5'h0f
`define CRS_SEL_PAIR3 5'h10
`define CRS_SEL_STATUS 5'h11
// Status word field positions
`define CRS_ST_EN1 0
`define CRS_ST_EN2 1
`define CRS_ST_MODE_LO 2
`define CRS_ST_MODE_HI 3
`define CRS_ST_BANK_AF 4
`define CRS_ST_BANK_GEN 5
// Fixed service addresses
`define CRS_NMI_ADDR 16'h0066
`define CRS_MODE1_ADDR 16'h0038
// Reset values
`define CRS_RST_WORD 16'h0000
`define CRS_RST_BYTE 8'h00
// Stack step per push or pop
`define CRS_SP_STEP 16'h0002
`endif

// >>> hw/crs_pkg.sv
package crs_pkg;
	// Maskable response mode, held in the mode flop pair
	typedef enum logic [1:0] {
		CRS_MODE_INSERT = 2'b00,
		CRS_MODE_FIXED = 2'b01,
		CRS_MODE_VECTOR = 2'b10
	} crs_mode_t;
	// Interrupt entry sequencer, Gray along idle, ack, enter
	typedef enum logic [1:0] {
		CRS_IDLE = 2'b00,
		CRS_ACK = 2'b01,
		CRS_ENTER = 2'b11
	} crs_state_t;
endpackage

// >>> verification/crs_core_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Checker on the register set ports
module crs_core_regs_props
(
	input wire logic clk,
	input wire logic reset,
	input wire logic nmi_req,
	input wire logic bus_request,
	input wire logic instr_last,
	input wire logic fetch_cycle,
	input wire logic push_op,
	input wire logic wr_en,
	input wire logic op_ei,
	input wire logic op_di,
	input wire logic op_retn,
	input wire logic ack_valid,
	input wire logic [7:0] ack_vector,
	input wire logic int_ack,
	input wire logic insert_opcode,
	input wire logic nmi_taken,
	input wire logic int_taken,
	input wire logic [15:0] pc_out,
	input wire logic [15:0] sp_out,
	input wire logic [7:0] refresh_addr,
	input wire logic refresh_drive,
	input wire logic enable_flop_first,
	input wire logic enable_flop_second,
	input wire logic [1:0] response_mode_flops
);
	// Vector byte seen at the acknowledge edge
	logic [7:0] vec_q;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	// Capture of the peripheral vector
	always_ff @(posedge clk)
	begin
		if (ack_valid && int_ack)
			vec_q <= ack_vector;
	end
	property p_nmi_go;
		instr_last && nmi_req && !bus_request && !int_ack |-> ##[2:3] nmi_taken;
	endproperty
	a_nmi_go: assert property (p_nmi_go) else $error("nmi entry missing");
	property p_nmi_addr;
		nmi_taken |-> pc_out == 16'h0066 && !enable_flop_first;
	endproperty
	a_nmi_addr: assert property (p_nmi_addr) else $error("nmi address");
	property p_mask;
		$rose(int_ack) |-> $past(instr_last) && $past(enable_flop_first) && !$past(nmi_req);
	endproperty
	a_mask: assert property (p_mask) else $error("maskable taken wrongly");
	property p_insert;
		$rose(int_ack) |-> insert_opcode == (response_mode_flops == 2'b00);
	endproperty
	a_insert: assert property (p_insert) else $error("insert flag wrong");
	property p_fixed;
		int_taken && response_mode_flops == 2'b01 |-> pc_out == 16'h0038;
	endproperty
	a_fixed: assert property (p_fixed) else $error("fixed address");
	property p_vec;
		int_ack && ack_valid && response_mode_flops == 2'b10
			|-> ##[1:2] pc_out[7:0] == {vec_q[7:1], 1'b0};
	endproperty
	a_vec: assert property (p_vec) else $error("vector low byte");
	property p_ei;
		op_ei |=> enable_flop_first && enable_flop_second;
	endproperty
	a_ei: assert property (p_ei) else $error("enable flops not set");
	property p_di;
		op_di |=> !enable_flop_first && !enable_flop_second;
	endproperty
	a_di: assert property (p_di) else $error("enable flops not cleared");
	property p_retn;
		op_retn |=> enable_flop_first == $past(enable_flop_second);
	endproperty
	a_retn: assert property (p_retn) else $error("return restore");
	property p_int_off;
		int_taken |-> !enable_flop_first && !enable_flop_second;
	endproperty
	a_int_off: assert property (p_int_off) else $error("enables left on");
	property p_push;
		push_op && !wr_en |=> sp_out == $past(sp_out) - 16'h0002;
	endproperty
	a_push: assert property (p_push) else $error("push step");
	property p_refr;
		fetch_cycle ##1 fetch_cycle |=> refresh_drive && refresh_addr == $past(refresh_addr) + 8'h01;
	endproperty
	a_refr: assert property (p_refr) else $error("refresh step");
	c_nmi: cover property (nmi_taken);
	c_vec: cover property (int_ack && ack_valid);
	c_ins: cover property (insert_opcode && fetch_cycle);
endmodule
`default_nettype wire

// >>> verification/crs_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Peripherals pulling the request lines
module crs_periph_model
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [1:0] pull_nmi,
	input wire logic [1:0] pull_int,
	input wire logic vec_on,
	input wire logic [2:0] slow,
	input wire logic [7:0] vec,
	input wire logic int_ack,
	output logic nmi_req,
	output logic int_req,
	output logic ack_valid,
	output logic [7:0] ack_vector
);
	// Wait count before answering
	logic [2:0] wait_q;
	assign nmi_req = |pull_nmi;
	assign int_req = |pull_int;
	always_ff @(posedge clk)
	begin
		if (reset || !int_ack || !vec_on || ack_valid)
		begin
			// Released bus toggles out of reset, holds 0x55 in reset
			wait_q <= 3'h0;
			ack_valid <= 1'b0;
			ack_vector <= reset ? 8'h55 : ~ack_vector;
		end
		else if (wait_q == slow)
		begin
			ack_valid <= 1'b1;
			ack_vector <= vec;
		end
		else
			wait_q <= wait_q + 3'h1;
	end
endmodule
`default_nettype wire

// >>> verification/tb_cpu_register_set_and_interrupt_entry.sv
`timescale 1ns/1ps
`default_nettype none
`include "crs_map.svh"
// ==========
// Bench for the register set and interrupt entry
module tb_cpu_register_set_and_interrupt_entry;
	localparam int LAST = 0, FETCH = 1, STEP = 2, PUSH = 3, POP = 4, SWAF = 5;
	localparam int SWGN = 6, EI = 7, DI = 8, RETN = 9, MODE = 10;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic bus_request = 1'b0;
	logic wr_en = 1'b0;
	logic vec_on = 1'b0;
	logic [10:0] st = 11'h000;
	logic [1:0] mode_val = 2'h0;
	logic [4:0] wr_sel = 5'h00;
	logic [4:0] rd_sel = 5'h00;
	logic [15:0] wr_data = 16'h0000;
	logic [1:0] pull_nmi = 2'h0;
	logic [1:0] pull_int = 2'h0;
	logic [2:0] slow = 3'h3;
	logic [7:0] vec = 8'h34;
	logic nmi_req, int_req, ack_valid, int_ack, insert_opcode, nmi_taken, int_taken;
	logic refresh_drive, enable_flop_first, enable_flop_second;
	logic [7:0] ack_vector, refresh_addr;
	logic [1:0] response_mode_flops;
	logic [15:0] rd_data, service_addr, pc_out, sp_out;
	int bad_count = 0, checks = 0, n_nmi = 0, n_int = 0;
	crs_core_regs crs_core_regs_inst (.*, .instr_last(st[LAST]), .fetch_cycle(st[FETCH]),
		.pc_step(st[STEP]), .push_op(st[PUSH]), .pop_op(st[POP]), .swap_af(st[SWAF]),
		.swap_gen(st[SWGN]), .op_ei(st[EI]), .op_di(st[DI]), .op_retn(st[RETN]),
		.op_mode(st[MODE]));
	crs_periph_model crs_periph_model_inst (.*);
	// Clock at 40 MHz
	always #12.5 clk = ~clk;
	// Entry pulse counters
	always @(posedge clk)
	begin
		if (nmi_taken === 1'b1)
			n_nmi++;
		if (int_taken === 1'b1)
			n_int++;
	end
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task go(input int b);
		@(posedge clk) st <= 11'h001 << b;
		@(posedge clk) st <= 11'h000;
	endtask
	task idle(input int n);
		repeat (n) @(posedge clk);
	endtask
	task wr(input logic [4:0] s, input logic [15:0] d);
		@(posedge clk) wr_en <= 1'b1;
		wr_sel <= s;
		wr_data <= d;
		@(posedge clk) wr_en <= 1'b0;
	endtask
	task rd(input logic [4:0] s, output logic [15:0] v);
		@(posedge clk) rd_sel <= s;
		idle(2);
		v = rd_data;
	endtask
	task rb(input logic [4:0] s, input logic [7:0] e);
		logic [15:0] v;
		rd(s, v);
		chk({8'h00, v[7:0]}, {8'h00, e});
	endtask
	task set_mode(input logic [1:0] m);
		@(posedge clk) mode_val <= m;
		go(MODE);
	endtask
	// Register table, pairs, unmapped and status
	task t_regs;
		logic [15:0] v;
		for (int i = 0; i < 10; i++)
			wr(i[4:0], {8'ha5, 8'h11 * i[7:0]});
		for (int i = 10; i < 14; i++)
			wr(i[4:0], {8'h13, 8'h11 * i[7:0]});
		for (int i = 0; i < 10; i++)
			rb(i[4:0], 8'h11 * i[7:0]);
		for (int i = 10; i < 14; i++)
		begin
			rd(i[4:0], v);
			chk(v, {8'h13, 8'h11 * i[7:0]});
		end
		rd(`CRS_SEL_PAIR1, v);
		chk(v, 16'h2233);
		wr(`CRS_SEL_PAIR3, 16'hbeef);
		rb(`CRS_SEL_H_HI, 8'hbe);
		rb(`CRS_SEL_H_LO, 8'hef);
		wr(5'h1f, 16'hffff);
		wr(`CRS_SEL_STATUS, 16'hffff);
		rd(5'h1f, v);
		chk(v, 16'h0000);
		rd(`CRS_SEL_STATUS, v);
		chk(v, 16'h0000);
	endtask
	// Bank swap keeps both copies
	task t_banks;
		logic [15:0] v;
		wr(`CRS_SEL_ACC, 16'h0011);
		go(SWAF);
		go(SWGN);
		wr(`CRS_SEL_ACC, 16'h0077);
		wr(`CRS_SEL_B_HI, 16'h0044);
		rd(`CRS_SEL_STATUS, v);
		chk(v & 16'h0030, 16'h0030);
		go(SWAF);
		go(SWGN);
		rb(`CRS_SEL_ACC, 8'h11);
		rb(`CRS_SEL_B_HI, 8'h22);
	endtask
	// Stack, refresh and program counter steps
	task t_steps;
		wr(`CRS_SEL_SP, 16'h1000);
		go(PUSH);
		go(PUSH);
		idle(1);
		chk(sp_out, 16'h0ffc);
		go(POP);
		go(POP);
		go(POP);
		idle(1);
		chk(sp_out, 16'h1002);
		wr(`CRS_SEL_REFRESH, 16'h00fe);
		@(posedge clk) st <= 11'h002;
		idle(2);
		st <= 11'h000;
		go(FETCH);
		rb(`CRS_SEL_REFRESH, 8'h01);
		wr(`CRS_SEL_PC, 16'h00ff);
		go(STEP);
		idle(1);
		chk(pc_out, 16'h0100);
	endtask
	// Both requests at once, then vectored entry
	task t_nmi;
		wr(`CRS_SEL_VBASE, 16'h0012);
		set_mode(2'h2);
		go(EI);
		pull_nmi <= 2'b01;
		pull_int <= 2'b10;
		go(LAST);
		pull_nmi <= 2'b00;
		idle(5);
		chk(16'(n_nmi), 16'h0001);
		chk(pc_out, 16'h0066);
		chk({enable_flop_first, enable_flop_second}, 16'h0001);
		go(LAST);
		idle(5);
		chk(16'(n_int), 16'h0000);
		go(RETN);
		vec_on <= 1'b1;
		go(LAST);
		pull_int <= 2'b00;
		idle(12);
		chk(pc_out, 16'h1234);
		chk(service_addr, 16'h1234);
		chk(16'(n_int), 16'h0001);
		vec_on <= 1'b0;
	endtask
	// Disabled, held off, fixed and insert modes
	task t_modes;
		set_mode(2'h1);
		go(DI);
		pull_int <= 2'b11;
		go(LAST);
		idle(5);
		chk(16'(n_int), 16'h0001);
		go(EI);
		bus_request <= 1'b1;
		go(LAST);
		idle(5);
		chk(16'(n_int), 16'h0001);
		bus_request <= 1'b0;
		go(LAST);
		pull_int <= 2'b00;
		idle(5);
		chk(pc_out, 16'h0038);
		chk(16'(n_int), 16'h0002);
		wr(`CRS_SEL_PC, 16'h4000);
		set_mode(2'h0);
		go(EI);
		pull_int <= 2'b01;
		go(LAST);
		pull_int <= 2'b00;
		idle(2);
		chk({insert_opcode, int_ack}, 16'h0003);
		chk(16'(n_int), 16'h0003);
		go(FETCH);
		idle(3);
		chk({insert_opcode, int_ack}, 16'h0000);
		chk(pc_out, 16'h4000);
		set_mode(2'h3);
		idle(1);
		chk({14'h0000, response_mode_flops}, 16'h0000);
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		idle(20);
		reset <= 1'b0;
		idle(2);
		chk({14'h0000, enable_flop_first, enable_flop_second}, 16'h0000);
		chk(pc_out, 16'h0000);
		t_regs;
		t_banks;
		t_steps;
		t_nmi;
		t_modes;
		wrap_up;
	end
	// Watchdog
	initial
	begin
		idle(5000);
		bad_count++;
		wrap_up;
	end
endmodule
bind crs_core_regs crs_core_regs_props crs_core_regs_props_inst (.*);
`default_nettype wire
